/* File: rtl/aphp_pkg.sv */
package aphp_pkg;
    localparam int DATA_W = 12;
    localparam int CREG_W = 10;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_LO_POS = 10;
    localparam int ADDR_HI_POS = 11;
    localparam logic [1:0] CREG0_ADDR = 2'h0;
    localparam logic [1:0] CREG1_ADDR = 2'h1;
    localparam int REF_SEL_POS = 0;
    localparam int FIFO_RST_POS = 1;
    localparam int STROBE_MODE_POS = 2;
    localparam logic [9:0] CREG0_RESET = 10'h000;
    localparam logic [9:0] CREG1_RESET = 10'h000;
    // Irq status and mask bit positions
    localparam int IRQ_OVF_POS = 0;
    localparam int IRQ_AVAIL_POS = 1;
    localparam int IRQ_W = 2;
    // Host-side control port offsets
    localparam logic [1:0] OFS_STATUS = 2'h0;
    localparam logic [1:0] OFS_MASK = 2'h1;
    localparam logic [1:0] OFS_CREG0 = 2'h2;
    localparam logic [1:0] OFS_CREG1 = 2'h3;
    // Port access states
    typedef enum logic [2:0] {
        APHP_IDLE = 3'b001,
        APHP_READ = 3'b010,
        APHP_WRITE = 3'b100
    } aphp_state_t;
endpackage

/* File: rtl/aphp_sync.sv */
`timescale 1ns/1ns
// Two-flop synchroniser per bit
module aphp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

/* File: rtl/aphp_fifo.sv */
`timescale 1ns/1ns
// Sample FIFO with overflow pulse
module aphp_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Write side
    input wire logic wr_valid_i,
    input wire logic [W-1:0] wr_data_i,
    output logic wr_ready_o,
    output logic overflow_o,
    // Read side
    input wire logic rd_ready_i,
    output logic rd_valid_o,
    output logic [W-1:0] rd_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;

    assign wr_ready_o = (cnt != (AW+1)'(DEPTH));
    assign rd_valid_o = (cnt != '0);
    assign rd_data_o = mem[rp];
    assign push = wr_valid_i && wr_ready_o;
    assign pop = rd_ready_i && rd_valid_o;
    // Write into full drops the sample and flags it
    assign overflow_o = wr_valid_i && !wr_ready_o;

    // Storage
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wp] <= wr_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= wp + AW'(1);
            end
            if (pop) begin
                rp <= rp + AW'(1);
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: rtl/aphp_port.sv */
`timescale 1ns/1ns
// Parallel processor port of a dual-channel sampling converter
module aphp_port #(
    parameter int DEPTH = aphp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Processor pins, asynchronous
    input wire logic select_active_low_i,
    input wire logic select_active_high_i,
    input wire logic write_pin_i,
    input wire logic read_strobe_n_i,
    input wire logic [aphp_pkg::DATA_W-1:0] data_i,
    output logic [aphp_pkg::DATA_W-1:0] data_o,
    output logic [aphp_pkg::DATA_W-1:0] data_oe_o,
    output logic fifo_overflow_flag_o,
    // Conversion results
    input wire logic sample_valid_i,
    input wire logic [aphp_pkg::DATA_W-1:0] sample_i,
    // Analog control
    output logic ref_external_o,
    output logic [aphp_pkg::CREG_W-1:0] creg0_o,
    output logic [aphp_pkg::CREG_W-1:0] creg1_o,
    // Control register port
    input wire logic [1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Interrupt
    output logic irq_o
);
    import aphp_pkg::*;

    logic s_csn;
    logic s_cs;
    logic s_wr;
    logic s_rdn;
    logic [DATA_W-1:0] s_data;
    logic [CREG_W-1:0] creg0;
    logic [CREG_W-1:0] creg1;
    logic strobe_mode;
    logic selected;
    logic rd_req;
    logic wr_req;
    logic rd_req_q;
    logic wr_req_q;
    logic rd_start;
    logic wr_start;
    logic fifo_rst;
    logic fifo_reset;
    logic ovf_pulse;
    logic f_valid;
    logic [DATA_W-1:0] f_data;
    logic pop;
    logic host_wr;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_evt;
    logic f_valid_q;
    aphp_state_t state;
    aphp_state_t next_state;

    // Pins are asynchronous to mclk
    aphp_sync #(.W(DATA_W + 4)) u_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .d_i({select_active_low_i, select_active_high_i, write_pin_i,
              read_strobe_n_i, data_i}),
        .q_o({s_csn, s_cs, s_wr, s_rdn, s_data})
    );

    // FIFO clears on hardware reset or the FIFO-reset control bit
    assign fifo_reset = reset_i || fifo_rst;

    aphp_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .reset_i(fifo_reset),
        .wr_valid_i(sample_valid_i),
        .wr_data_i(sample_i),
        .wr_ready_o(),
        .overflow_o(ovf_pulse),
        .rd_ready_i(pop),
        .rd_valid_o(f_valid),
        .rd_data_o(f_data)
    );

    assign strobe_mode = creg1[STROBE_MODE_POS];
    assign selected = !s_csn && s_cs;
    // Strobe mode: write pin low writes, read strobe low reads
    // Direction mode: write pin high reads, low writes; read strobe ignored
    assign wr_req = selected && !s_wr;
    assign rd_req = selected && (strobe_mode ? !s_rdn : s_wr);
    assign rd_start = rd_req && !rd_req_q;
    assign wr_start = wr_req && !wr_req_q;
    // One FIFO word per read access
    assign pop = rd_start && f_valid && (state == APHP_IDLE);

    // Access request history for edge detection
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rd_req_q <= 1'b0;
            wr_req_q <= 1'b0;
        end else begin
            rd_req_q <= rd_req;
            wr_req_q <= wr_req;
        end
    end

    // Access state
    always_comb begin
        next_state = state;
        case (state)
            APHP_IDLE: begin
                if (rd_start) begin
                    next_state = APHP_READ;
                end else if (wr_start) begin
                    next_state = APHP_WRITE;
                end
            end
            APHP_READ: begin
                if (!rd_req) begin
                    next_state = APHP_IDLE;
                end
            end
            APHP_WRITE: begin
                if (!wr_req) begin
                    next_state = APHP_IDLE;
                end
            end
            default: begin
                next_state = APHP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state <= APHP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Read data and bus drive; bus floats outside a read
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            data_o <= '0;
            data_oe_o <= '0;
        end else begin
            if (pop) begin
                data_o <= f_data;
            end
            data_oe_o <= {DATA_W{next_state == APHP_READ}};
        end
    end

    assign host_wr = wr_i && (addr_i == OFS_CREG0 || addr_i == OFS_CREG1);

    // Control registers: pin writes address by top data bits
    // Strobe mode resets to direction select; host writes it after the first direction read
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            creg0 <= CREG0_RESET;
            creg1 <= CREG1_RESET;
            fifo_rst <= 1'b0;
        end else begin
            fifo_rst <= 1'b0;
            if (wr_start && state == APHP_IDLE) begin
                if ({s_data[ADDR_HI_POS], s_data[ADDR_LO_POS]} == CREG0_ADDR) begin
                    creg0 <= s_data[CREG_W-1:0];
                    fifo_rst <= s_data[FIFO_RST_POS];
                end else if ({s_data[ADDR_HI_POS], s_data[ADDR_LO_POS]} == CREG1_ADDR) begin
                    creg1 <= s_data[CREG_W-1:0];
                end
            end else if (host_wr) begin
                if (addr_i == OFS_CREG0) begin
                    creg0 <= wdata_i[CREG_W-1:0];
                    fifo_rst <= wdata_i[FIFO_RST_POS];
                end else begin
                    creg1 <= wdata_i[CREG_W-1:0];
                end
            end
        end
    end

    // Overflow flag: sticky, cleared only by the two resets
    always_ff @(posedge mclk_i) begin
        if (fifo_reset) begin
            fifo_overflow_flag_o <= 1'b0;
        end else if (ovf_pulse) begin
            fifo_overflow_flag_o <= 1'b1;
        end
    end

    // Registered copies for analog control
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ref_external_o <= 1'b0;
            creg0_o <= CREG0_RESET;
            creg1_o <= CREG1_RESET;
        end else begin
            ref_external_o <= creg0[REF_SEL_POS];
            creg0_o <= creg0;
            creg1_o <= creg1;
        end
    end

    // Interrupt events: overflow and data becoming available
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            f_valid_q <= 1'b0;
        end else begin
            f_valid_q <= f_valid;
        end
    end

    assign irq_evt = {f_valid && !f_valid_q, ovf_pulse};

    // Sticky status, write one clears, set wins over clear
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~((wr_i && addr_i == OFS_STATUS) ?
                         wdata_i[IRQ_W-1:0] : '0)) | irq_evt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_mask <= '0;
        end else if (wr_i && addr_i == OFS_MASK) begin
            irq_mask <= wdata_i[IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // Read data one cycle after strobe; zero otherwise
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                OFS_STATUS: rdata_o <= {30'h0, irq_stat};
                OFS_MASK: rdata_o <= {30'h0, irq_mask};
                OFS_CREG0: rdata_o <= {22'h0, creg0};
                OFS_CREG1: rdata_o <= {22'h0, creg1};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end
endmodule

/* File: tb/aphp_port_checker.sv */
`timescale 1ns/1ns
// Pin-side checks of the parallel port, ports only
module aphp_port_checker #(
    parameter int DEPTH = aphp_pkg::FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic select_active_low_i,
    input wire logic select_active_high_i,
    input wire logic write_pin_i,
    input wire logic read_strobe_n_i,
    input wire logic [aphp_pkg::DATA_W-1:0] data_i,
    input wire logic [aphp_pkg::DATA_W-1:0] data_oe_o,
    input wire logic fifo_overflow_flag_o,
    input wire logic sample_valid_i,
    input wire logic ref_external_o,
    input wire logic [aphp_pkg::CREG_W-1:0] creg0_o,
    input wire logic [aphp_pkg::CREG_W-1:0] creg1_o,
    input wire logic [1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i
);
    import aphp_pkg::*;
    logic sel;
    logic clr_req;
    logic [3:0] idle_cnt;
    logic [3:0] clr_age;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    assign sel = !select_active_low_i && select_active_high_i;
    // Any FIFO reset request, loose on purpose since pins are async
    assign clr_req = (wr_i && addr_i == OFS_CREG0 && wdata_i[FIFO_RST_POS])
        || (sel && data_i[ADDR_HI_POS:ADDR_LO_POS] == CREG0_ADDR && data_i[FIFO_RST_POS]);
    // Saturating ages so a long run cannot wrap them
    always_ff @(posedge mclk_i) begin
        idle_cnt <= (reset_i || sel) ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hf};
        clr_age <= (reset_i || clr_req) ? 4'h0 : clr_age + {3'h0, clr_age != 4'hf};
    end
    a_oe_whole_bus: assert property (data_oe_o == '0 || data_oe_o == '1)
        else $error("bus partly driven");
    a_oe_needs_sel: assert property ($rose(data_oe_o[0]) |-> $past(sel, 2) && $past(sel, 3))
        else $error("bus driven without both selects");
    a_oe_strobe_rd: assert property ($rose(data_oe_o[0]) && creg1_o[STROBE_MODE_POS]
        |-> !$past(read_strobe_n_i, 2))
        else $error("strobe mode read without read strobe");
    a_oe_dir_rd: assert property ($rose(data_oe_o[0]) && !creg1_o[STROBE_MODE_POS]
        |-> $past(write_pin_i, 2))
        else $error("direction mode read with write direction");
    a_oe_released: assert property (idle_cnt >= 4'h7 |-> data_oe_o == '0)
        else $error("bus still driven after deselect");
    a_flag_rises: assert property ($rose(fifo_overflow_flag_o) |-> $past(sample_valid_i, 1)
        || $past(sample_valid_i, 2) || $past(sample_valid_i, 3))
        else $error("overflow flag without a sample write");
    a_flag_holds: assert property ($fell(fifo_overflow_flag_o)
        |-> $past(reset_i) || clr_age < 4'h8)
        else $error("overflow flag cleared without reset");
    a_creg_defaults: assert property ($past(reset_i)
        |-> creg0_o == CREG0_RESET && creg1_o == CREG1_RESET)
        else $error("control registers not at defaults");
    a_ref_tracks: assert property (ref_external_o == creg0_o[REF_SEL_POS])
        else $error("reference select differs from register");
endmodule
bind aphp_port aphp_port_checker #(.DEPTH(DEPTH)) aphp_port_checker_inst (
    .mclk_i(mclk_i), .reset_i(reset_i), .select_active_low_i(select_active_low_i),
    .select_active_high_i(select_active_high_i), .write_pin_i(write_pin_i),
    .read_strobe_n_i(read_strobe_n_i), .data_i(data_i), .data_oe_o(data_oe_o),
    .fifo_overflow_flag_o(fifo_overflow_flag_o), .sample_valid_i(sample_valid_i),
    .ref_external_o(ref_external_o), .creg0_o(creg0_o), .creg1_o(creg1_o),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i));

/* File: tb/aphp_host_model.sv */
`timescale 1ns/1ns
// Processor bus master on the converter pins
module aphp_host_model (
    // Clock
    input wire logic mclk_i,
    // Wire level and device enables
    input wire logic [aphp_pkg::DATA_W-1:0] bus_i,
    input wire logic [aphp_pkg::DATA_W-1:0] dev_oe_i,
    // Pins toward the device
    output logic select_active_low_o,
    output logic select_active_high_o,
    output logic write_pin_o,
    output logic read_strobe_n_o,
    output logic [aphp_pkg::DATA_W-1:0] bus_o
);
    import aphp_pkg::*;
    initial begin
        select_active_low_o = 1'b1;
        select_active_high_o = 1'b0;
        write_pin_o = 1'b1;
        read_strobe_n_o = 1'b1;
        bus_o = 12'h5a5;
    end
    // Held long because the pins cross a synchroniser
    task automatic access(input logic sm, input logic wr, input logic both,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic drv);
        @(posedge mclk_i);
        select_active_low_o <= 1'b0;
        select_active_high_o <= both;
        write_pin_o <= !wr;
        read_strobe_n_o <= sm ~^ wr;
        bus_o <= wr ? d : ~bus_o;
        repeat (6) @(posedge mclk_i);
        q = bus_i;
        drv = dev_oe_i[0];
        select_active_low_o <= 1'b1;
        select_active_high_o <= 1'b0;
        write_pin_o <= 1'b1;
        read_strobe_n_o <= 1'b1;
        bus_o <= ~bus_o; // Released bus keeps no stale value
        repeat (6) @(posedge mclk_i);
    endtask
endmodule

/* File: tb/aphp_port_tb_top.sv */
`timescale 1ns/1ns
module aphp_port_tb_top;
    import aphp_pkg::*;
    logic mclk_i, reset_i, sample_valid_i, wr_i, rd_i, irq_o, ref_external_o, flag;
    logic sel_n, sel, wpin, rd_n, drv, i0, i3;
    logic [11:0] host_bus, pin_bus, data_o, data_oe_o, sample_i, got, cfg;
    logic [9:0] creg0_o, creg1_o;
    logic [1:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rdat, seed;
    logic [11:0] exp_q[$];
    int error_cnt, checks_done;
    // Wire level: device data where its enables are set, host level elsewhere
    assign pin_bus = (data_oe_o & data_o) | (~data_oe_o & host_bus);
    aphp_port #(.DEPTH(16)) aphp_port_inst (.mclk_i(mclk_i), .reset_i(reset_i),
        .select_active_low_i(sel_n), .select_active_high_i(sel), .write_pin_i(wpin),
        .read_strobe_n_i(rd_n), .data_i(pin_bus), .data_o(data_o), .data_oe_o(data_oe_o),
        .fifo_overflow_flag_o(flag), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
        .ref_external_o(ref_external_o), .creg0_o(creg0_o), .creg1_o(creg1_o),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o));
    aphp_host_model aphp_host_model_inst (.mclk_i(mclk_i), .bus_i(pin_bus),
        .dev_oe_i(data_oe_o), .select_active_low_o(sel_n), .select_active_high_o(sel),
        .write_pin_o(wpin), .read_strobe_n_o(rd_n), .bus_o(host_bus));
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic host(input logic sm, input logic wr, input logic both, input logic [11:0] d);
        aphp_host_model_inst.access(sm, wr, both, d, got, drv);
    endtask
    // One register port cycle, read data taken in the cycle after
    task automatic preg(input logic w, input logic [1:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1 rdat = rdata_o;
        repeat (2) @(posedge mclk_i);
    endtask
    task automatic push(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            sample_valid_i <= 1'b1;
            void'(next_rand());
            sample_i <= seed[11:0];
            exp_q.push_back(seed[11:0]);
            @(posedge mclk_i);
            sample_valid_i <= 1'b0;
        end
        repeat (4) @(posedge mclk_i);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {reset_i, sample_valid_i, wr_i, rd_i, addr_i, wdata_i, sample_i} = '0;
        reset_i = 1'b1;
        seed = 32'h37;
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1 chk("creg0 reset", creg0_o, CREG0_RESET);
        // First pin access is a write: external reference on
        host(1'b0, 1'b1, 1'b1, {CREG0_ADDR, 10'h001});
        chk("ref select", ref_external_o, 1'b1);
        chk("creg0", creg0_o, 10'h001);
        push(3);
        host(1'b0, 1'b0, 1'b1, 12'h000);
        chk("direction read", got, exp_q.pop_front());
        chk("bus driven", drv, 1'b1);
        chk("bus released", data_oe_o, 12'h000);
        void'(next_rand());
        cfg = {CREG1_ADDR, seed[9:0] | 10'h004};
        host(1'b0, 1'b1, 1'b1, cfg);
        chk("creg1", creg1_o, cfg[9:0]);
        chk("no drive on write", drv, 1'b0);
        host(1'b1, 1'b0, 1'b0, 12'h000);
        chk("one select", drv, 1'b0);
        host(1'b1, 1'b0, 1'b1, 12'h000);
        chk("strobe read", got, exp_q.pop_front());
        $display("test pins done");
        // One word left, so fifteen more fill the FIFO exactly
        push(15);
        chk("flag at full", flag, 1'b0);
        push(1);
        chk("flag on overflow", flag, 1'b1);
        host(1'b1, 1'b0, 1'b1, 12'h000);
        chk("read at full", got, exp_q.pop_front());
        chk("flag after read", flag, 1'b1);
        preg(1'b1, OFS_MASK, 32'h0);
        i0 = irq_o;
        preg(1'b1, OFS_MASK, 32'h3);
        i3 = irq_o;
        chk("irq masked", i0, 1'b0);
        chk("irq unmasked", i3, 1'b1);
        preg(1'b0, OFS_STATUS, 32'h0);
        chk("status overflow", rdat[0], 1'b1);
        host(1'b1, 1'b1, 1'b1, {CREG0_ADDR, 10'h003});
        chk("flag fifo reset", flag, 1'b0);
        preg(1'b1, OFS_MASK, 32'h3);
        preg(1'b1, OFS_STATUS, 32'h3);
        chk("irq cleared", irq_o, 1'b0);
        $display("test overflow done");
        // Overflow again so that the hardware reset has a flag to clear
        push(17);
        chk("flag again", flag, 1'b1);
        reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        #1 chk("creg1 reset", creg1_o, CREG1_RESET);
        chk("ref reset", ref_external_o, 1'b0);
        chk("flag reset", flag, 1'b0);
        $display("test reset done");
        // Register port path into control register 0
        void'(next_rand());
        cfg = seed[11:0];
        preg(1'b1, OFS_CREG0, {22'h0, cfg[9:0]});
        preg(1'b0, OFS_CREG0, 32'h0);
        chk("port creg0", rdat, {22'h0, cfg[9:0]});
        chk("port ref", ref_external_o, cfg[0]);
        $display("test port done");
        report_and_stop();
    end
endmodule
